// file: hw/egdm_map.svh
`ifndef EGDM_MAP_SVH
`define EGDM_MAP_SVH

// Register byte offsets on the plain register port.
`define EGDM_OFS_GEAR_NUM   8'h00
`define EGDM_OFS_GEAR_DEN   8'h04
`define EGDM_OFS_LOOP_GAIN  8'h08
`define EGDM_OFS_FF_GAIN    8'h0c
`define EGDM_OFS_SMOOTH     8'h10
`define EGDM_OFS_FF_FILT    8'h14
`define EGDM_OFS_INPOS_W    8'h18
`define EGDM_OFS_OVR_THR    8'h1c
`define EGDM_OFS_CLR_MODE   8'h20
`define EGDM_OFS_OUT_CODE   8'h24
`define EGDM_OFS_CONTROL    8'h28
`define EGDM_OFS_STATUS     8'h2c
`define EGDM_OFS_DROOP      8'h30

// Reset values of the settings.
`define EGDM_RST_GEAR       15'h0001
`define EGDM_RST_LOOP_GAIN  8'h19
`define EGDM_RST_INPOS_W    15'h0064
`define EGDM_RST_OVR_THR    19'h09c40
`define EGDM_RST_OUT_CODE   8'h24

// Setting limits; gain per second, percent, milliseconds, pulses.
`define EGDM_MAX_LOOP_GAIN  32'd150
`define EGDM_MAX_FF_GAIN    32'd100
`define EGDM_MAX_SMOOTH_MS  32'd50000
`define EGDM_MAX_FILT_MS    32'd5000
`define EGDM_MAX_OVR_THR    32'd400000

// Special codes.
`define EGDM_OVR_OFF        19'h0270f
`define EGDM_CODE_POS       8'h24
`define EGDM_CODE_NEG       8'h88
`define EGDM_FILT_SHIFT     4

// Timing: clock period and the one millisecond sample tick.
`define EGDM_CLK_NS         50
`define EGDM_TICK_NS        1000000
`define EGDM_TICK_CYC       (`EGDM_TICK_NS / `EGDM_CLK_NS)

`endif

// file: hw/egdm_pkg.sv
package egdm_pkg;

  // Signed deviation count.
  typedef logic signed [23:0] egdm_cnt_t;

  // Speed command word.
  typedef logic signed [31:0] egdm_spd_t;

  // Settings written by software.
  typedef struct packed {
    logic [14:0] gear_num;
    logic [14:0] gear_den;
    logic [7:0]  kp;
    logic [6:0]  ffg;
    logic [15:0] smooth;
    logic [12:0] tau;
    logic [14:0] width;
    logic [18:0] thr;
    logic        clr_mode;
    logic [7:0]  ocode;
  } egdm_cfg_t;

endpackage

// file: hw/egdm_core.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "egdm_map.svh"
// Notes on behaviour
// R1: Encoder edges counted four per line.
// R2: Command pulses scaled by numerator over denominator.
// R3: Keep gear ratio between 1/50 and 20; the code does not check the ratio of the written gear values.
// R4: Droop accumulates scaled command minus feedback.
// R5: Allow three over loop gain settling.
// R6: In-position when droop below width, default 100.
// R7: Code 36 active high, 136 active low.
// R8: Droop above threshold trips fault, cuts drive.
// R9: Threshold 9999 disables the overrun fault.
// R10: Loop gain default 25, range 0-150.
// R11: Feed-forward gain 0-100 percent, default 0.
// R12: Feed-forward passes lag filter, 0-5 s.
// R13: Optional smoothing spaces out scaled pulses.
// R14: Gear values 0-32767, both default one.
// R15: Smoothing time 0-50 s, default zero; the code counts the setting, up to 50000, in sys_clk cycles, not milliseconds.
// R16: Clear mode 0 zeroes counter on rise.
// R17: Signed counter; compares use its magnitude.
module egdm_core #(
  parameter int unsigned TICK_CYC = `EGDM_TICK_CYC
) (
  // Clock, reset and clock enable.
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Register port.
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Command and encoder pins.
  input  wire logic              cmd_pulse_in,
  input  wire logic              cmd_dir_in,
  input  wire logic              enc_a_in,
  input  wire logic              enc_b_in,
  input  wire logic              counter_clear_input,
  // Status and drive outputs.
  output logic                   in_position_output,
  output logic                   position_overrun_fault,
  output logic                   drive_enable,
  output egdm_pkg::egdm_spd_t    speed_cmd
);
  import egdm_pkg::*;

  // Limits a written value to its range.
  function automatic logic [31:0] lim(input logic [31:0] v, input logic [31:0] m);
    lim = (v > m) ? m : v;
  endfunction

  // Pin order: {clear, dir, pulse, b, a}.
  logic [4:0]        s0_r;
  logic [4:0]        s1_r;
  logic [4:0]        s2_r;
  logic [4:0]        s0_nxt;
  logic [4:0]        s1_nxt;
  logic [4:0]        s2_nxt;
  egdm_cfg_t         cfg_r;
  egdm_cfg_t         cfg_nxt;
  logic              fclr;
  logic [31:0]       rdata_nxt;
  logic signed [31:0] acc_r;
  logic signed [31:0] acc_nxt;
  logic signed [31:0] gden;
  logic signed [31:0] gadd;
  logic [15:0]       sp_r;
  logic [15:0]       sp_nxt;
  egdm_cnt_t         droop_r;
  egdm_cnt_t         droop_nxt;
  egdm_cnt_t         mag;
  logic              in_pos_r;
  logic              in_pos_nxt;
  logic              fault_nxt;
  logic              ipo_nxt;
  egdm_spd_t         spd_nxt;
  logic [14:0]       tick_r;
  logic [14:0]       tick_nxt;
  logic signed [15:0] rate_r;
  logic signed [15:0] rate_nxt;
  logic [8:0]        fcnt_r;
  logic [8:0]        fcnt_nxt;
  egdm_spd_t         ffy_r;
  egdm_spd_t         ffy_nxt;
  egdm_spd_t         ffx;
  logic [8:0]        per;
  logic              tick;
  logic              cmd_hit;
  logic              clr_rise;
  logic              clr_now;
  logic              fb_fwd;
  logic              fb_rev;
  logic              gate;
  logic              cmd_up;
  logic              cmd_dn;

  // Every pin passes two flops; the third stage only feeds edge detection.
  always_comb begin
    s0_nxt = {counter_clear_input, cmd_dir_in, cmd_pulse_in, enc_b_in, enc_a_in};
    s1_nxt = s0_r;
    s2_nxt = s1_r;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s0_r <= 5'h00;
      s1_r <= 5'h00;
      s2_r <= 5'h00;
    end else if (ce) begin
      s0_r <= s0_nxt;
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  // Edge decode. A move where both channels flip at once is dropped,
  // because its direction cannot be known.
  always_comb begin
    cmd_hit  = s1_r[2] & ~s2_r[2];
    clr_rise = s1_r[4] & ~s2_r[4];
    clr_now  = cfg_r.clr_mode ? s1_r[4] : clr_rise; // R16
    fb_fwd   = ((s1_r[0] ^ s2_r[0]) ^ (s1_r[1] ^ s2_r[1])) & (s1_r[0] ^ s2_r[1]); // R1
    fb_rev   = ((s1_r[0] ^ s2_r[0]) ^ (s1_r[1] ^ s2_r[1])) & ~(s1_r[0] ^ s2_r[1]); // R1
  end

  // Settings, control and read-back. Writes above a range are clamped, except gear and width, which keep their low 15 bits.
  always_comb begin
    cfg_nxt   = cfg_r;
    fclr      = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `EGDM_OFS_GEAR_NUM:  cfg_nxt.gear_num = reg_wdata[14:0]; // R14
        `EGDM_OFS_GEAR_DEN:  cfg_nxt.gear_den = reg_wdata[14:0]; // R14
        `EGDM_OFS_LOOP_GAIN: cfg_nxt.kp = 8'(lim(reg_wdata, `EGDM_MAX_LOOP_GAIN)); // R10
        `EGDM_OFS_FF_GAIN:   cfg_nxt.ffg = 7'(lim(reg_wdata, `EGDM_MAX_FF_GAIN)); // R11
        `EGDM_OFS_SMOOTH:    cfg_nxt.smooth = 16'(lim(reg_wdata, `EGDM_MAX_SMOOTH_MS)); // R15
        `EGDM_OFS_FF_FILT:   cfg_nxt.tau = 13'(lim(reg_wdata, `EGDM_MAX_FILT_MS)); // R12
        `EGDM_OFS_INPOS_W:   cfg_nxt.width = reg_wdata[14:0]; // R6
        `EGDM_OFS_OVR_THR:   cfg_nxt.thr = 19'(lim(reg_wdata, `EGDM_MAX_OVR_THR)); // R8
        `EGDM_OFS_CLR_MODE:  cfg_nxt.clr_mode = reg_wdata[0];
        `EGDM_OFS_OUT_CODE:  cfg_nxt.ocode = reg_wdata[7:0];
        `EGDM_OFS_CONTROL:   fclr = reg_wdata[0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `EGDM_OFS_GEAR_NUM:  rdata_nxt = {17'h0, cfg_r.gear_num};
        `EGDM_OFS_GEAR_DEN:  rdata_nxt = {17'h0, cfg_r.gear_den};
        `EGDM_OFS_LOOP_GAIN: rdata_nxt = {24'h0, cfg_r.kp};
        `EGDM_OFS_FF_GAIN:   rdata_nxt = {25'h0, cfg_r.ffg};
        `EGDM_OFS_SMOOTH:    rdata_nxt = {16'h0, cfg_r.smooth};
        `EGDM_OFS_FF_FILT:   rdata_nxt = {19'h0, cfg_r.tau};
        `EGDM_OFS_INPOS_W:   rdata_nxt = {17'h0, cfg_r.width};
        `EGDM_OFS_OVR_THR:   rdata_nxt = {13'h0, cfg_r.thr};
        `EGDM_OFS_CLR_MODE:  rdata_nxt = {31'h0, cfg_r.clr_mode};
        `EGDM_OFS_OUT_CODE:  rdata_nxt = {24'h0, cfg_r.ocode};
        `EGDM_OFS_STATUS:    rdata_nxt = {30'h0, position_overrun_fault, in_pos_r};
        `EGDM_OFS_DROOP:     rdata_nxt = 32'(droop_r);
        default:             rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r          <= '0;
      cfg_r.gear_num <= `EGDM_RST_GEAR; // R14
      cfg_r.gear_den <= `EGDM_RST_GEAR; // R14
      cfg_r.kp       <= `EGDM_RST_LOOP_GAIN; // R10
      cfg_r.width    <= `EGDM_RST_INPOS_W; // R6
      cfg_r.thr      <= `EGDM_RST_OVR_THR; // R8
      cfg_r.ocode    <= `EGDM_RST_OUT_CODE;
      reg_rdata      <= 32'h0000_0000;
    end else if (ce) begin
      cfg_r     <= cfg_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // Electronic gear: each command pulse adds the numerator, signed by direction, to a residue,
  // and one scaled pulse leaves per denominator. With smoothing on, the
  // pulses are spread out, so a large ratio drains as a ramp, not a burst.
  always_comb begin
    gden   = {17'h0, cfg_r.gear_den};
    gadd   = cmd_hit ? (s1_r[3] ? {17'h0, cfg_r.gear_num} : -{17'h0, cfg_r.gear_num}) : 32'h0;
    gate   = (cfg_r.smooth == 16'h0) || (sp_r == 16'h0); // R13
    cmd_up = (gden != 32'h0) && gate && (acc_r >= gden); // R2
    cmd_dn = (gden != 32'h0) && gate && (acc_r <= -gden); // R2
    acc_nxt = acc_r + gadd - (cmd_up ? gden : 32'h0) + (cmd_dn ? gden : 32'h0); // R2
    sp_nxt = (cmd_up || cmd_dn) ? cfg_r.smooth : ((sp_r != 16'h0) ? sp_r - 16'h1 : 16'h0); // R13
  end

  // Deviation counter and its comparisons. Set of the fault wins over clear.
  always_comb begin
    droop_nxt = droop_r + 24'(cmd_up) - 24'(cmd_dn) - 24'(fb_fwd) + 24'(fb_rev); // R4 R17
    if (clr_now) begin
      droop_nxt = 24'h00_0000; // R16
    end
    mag        = droop_r[23] ? -droop_r : droop_r; // R17
    in_pos_nxt = mag < {9'h0, cfg_r.width}; // R6
    fault_nxt  = ((cfg_r.thr != `EGDM_OVR_OFF) && (mag > {5'h0, cfg_r.thr})) // R8 R9
                 || (position_overrun_fault && !fclr);
    case (cfg_r.ocode)
      `EGDM_CODE_POS: ipo_nxt = in_pos_nxt; // R7
      `EGDM_CODE_NEG: ipo_nxt = ~in_pos_nxt; // R7
      default:        ipo_nxt = 1'b0;
    endcase
    spd_nxt = 32'(droop_r * $signed({1'b0, cfg_r.kp})) + ffy_r; // R11
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_r                  <= 32'h0000_0000;
      sp_r                   <= 16'h0000;
      droop_r                <= 24'h00_0000;
      in_pos_r               <= 1'b0;
      in_position_output     <= 1'b0;
      position_overrun_fault <= 1'b0;
      drive_enable           <= 1'b0;
      speed_cmd              <= 32'h0000_0000;
    end else if (ce) begin
      acc_r                  <= acc_nxt;
      sp_r                   <= sp_nxt;
      droop_r                <= droop_nxt;
      in_pos_r               <= in_pos_nxt;
      in_position_output     <= ipo_nxt;
      position_overrun_fault <= fault_nxt;
      drive_enable           <= ~fault_nxt; // R8
      speed_cmd              <= spd_nxt;
    end
  end

  // Feed-forward: scaled pulses per millisecond times the gain, then a
  // first-order lag stepping one sixteenth of the gap every tau/16 ms.
  // The coarse step keeps the filter free of a divider.
  always_comb begin
    tick     = tick_r == 15'(TICK_CYC - 1);
    tick_nxt = tick ? 15'h0000 : tick_r + 15'h0001;
    rate_nxt = rate_r + 16'(cmd_up) - 16'(cmd_dn);
    ffx      = 32'(rate_r * $signed({1'b0, cfg_r.ffg})); // R11
    per      = 9'(cfg_r.tau >> `EGDM_FILT_SHIFT);
    fcnt_nxt = fcnt_r;
    ffy_nxt  = ffy_r;
    if (tick) begin
      // The pulse of the tick cycle opens the next window, so none is lost.
      rate_nxt = 16'(cmd_up) - 16'(cmd_dn);
      if (per == 9'h000) begin
        ffy_nxt = ffx; // R12
      end else if (fcnt_r + 9'h001 >= per) begin
        fcnt_nxt = 9'h000;
        ffy_nxt  = ffy_r + ((ffx - ffy_r) >>> `EGDM_FILT_SHIFT); // R12
      end else begin
        fcnt_nxt = fcnt_r + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_r <= 15'h0000;
      rate_r <= 16'h0000;
      fcnt_r <= 9'h000;
      ffy_r  <= 32'h0000_0000;
    end else if (ce) begin
      tick_r <= tick_nxt;
      rate_r <= rate_nxt;
      fcnt_r <= fcnt_nxt;
      ffy_r  <= ffy_nxt;
    end
  end

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_FB_X4: assert property ( // R1
    ce && fb_fwd && !cmd_up && !cmd_dn && !clr_now |=> droop_r == $past(droop_r) - 24'sh1)
    else $error("feedback edge did not lower droop by one");

  AST_GEAR_STEP: assert property ( // R2
    ce && gate && gden != 32'h0 && acc_r >= gden && !cmd_hit
    |=> acc_r == $past(acc_r) - $past(gden) && $past(cmd_up))
    else $error("gear residue did not drop by denominator");

  AST_DROOP_SUM: assert property ( // R4
    ce && cmd_up && !fb_fwd && !fb_rev && !clr_now |=> droop_r == $past(droop_r) + 24'sh1)
    else $error("scaled pulse did not raise droop");

  AST_INPOS: assert property ( // R6
    ce |=> in_pos_r == ($past(mag) < {9'h0, $past(cfg_r.width)}))
    else $error("in-position flag disagrees with droop");

  AST_POL_NEG: assert property ( // R7
    ce && cfg_r.ocode == `EGDM_CODE_NEG |=> in_position_output == !in_pos_r)
    else $error("negative logic output not inverted");

  AST_OVR: assert property ( // R8
    ce && cfg_r.thr != `EGDM_OVR_OFF && mag > {5'h0, cfg_r.thr}
    |=> position_overrun_fault && !drive_enable)
    else $error("overrun fault not raised");

  AST_OVR_OFF: assert property ( // R9
    ce && cfg_r.thr == `EGDM_OVR_OFF && !position_overrun_fault |=> !position_overrun_fault)
    else $error("overrun fault raised while disabled");

  AST_CLR: assert property ( // R16
    ce && !cfg_r.clr_mode && clr_rise |=> droop_r == 24'sh0 && !$stable(s2_r) || droop_r == 24'sh0)
    else $error("clear edge did not zero droop");

endmodule

// file: testbench/egdm_pulse_src.sv
`timescale 1ns/1ps
// Far-side model: command pulse source and quadrature encoder, both synchronous to sys_clk.
module egdm_pulse_src (
  // Clock.
  input  wire logic sys_clk,
  // Pins toward the drive.
  output logic      cmd_pulse,
  output logic      cmd_dir,
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] phase = 2'h0;

  // Idle levels at time zero.
  initial begin
    cmd_pulse = 1'b0;
    cmd_dir   = 1'b1;
    enc_a     = 1'b0;
    enc_b     = 1'b0;
  end

  // One quadrature edge per step, three cycles apart so the synchroniser never misses one.
  task automatic enc_steps(input int n, input logic fwd);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      phase = fwd ? phase + 2'h1 : phase - 2'h1;
      enc_a <= phase[1] ^ phase[0];
      enc_b <= phase[1];
      repeat (2) @(posedge sys_clk);
    end
  endtask

  // Command pulses held high three cycles and low three cycles.
  task automatic cmd_pulses(input int n, input logic fwd);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      cmd_dir   <= fwd;
      cmd_pulse <= 1'b1;
      repeat (3) @(posedge sys_clk);
      cmd_pulse <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule

// file: testbench/test_electronic_gear_deviation_monitor.sv
`timescale 1ns/1ps
module test_electronic_gear_deviation_monitor;
  import egdm_pkg::*;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic                ce = 1'b1;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic                clr_in = 1'b0;
  logic [31:0]         reg_rdata;
  logic                inpos, fault, drv, cp, cd, ea, eb;
  egdm_spd_t           spd;
  logic [31:0]         d;
  int                  miscompares = 0;
  int                  num_checks = 0;
  localparam logic [7:0]  RA[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                                     8'h24, 8'h3c};
  localparam logic [31:0] RV[10] = '{1, 1, 25, 0, 0, 0, 100, 40000, 36, 0};
  localparam logic [7:0]  CA[5] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  localparam logic [31:0] CW[5] = '{200, 101, 60000, 6000, 500000};
  localparam logic [31:0] CM[5] = '{150, 100, 50000, 5000, 400000};
  localparam logic [31:0] CR[5] = '{25, 0, 0, 0, 40000};

  always #25 sys_clk = ~sys_clk;

  // Clock enable is driven by the bench so that freezing can be checked.
  egdm_core #(.TICK_CYC(20)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_pulse_in(cp), .cmd_dir_in(cd), .enc_a_in(ea), .enc_b_in(eb),
    .counter_clear_input(clr_in), .in_position_output(inpos), .position_overrun_fault(fault),
    .drive_enable(drv), .speed_cmd(spd));

  egdm_pulse_src src (.sys_clk(sys_clk), .cmd_pulse(cp), .cmd_dir(cd), .enc_a(ea), .enc_b(eb));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask

  // Outputs are compared at a falling edge, well clear of the launching edge.
  task automatic outs(input int n, input logic ip, input logic f);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, inpos}, {31'h0, ip});
    chk({31'h0, fault}, {31'h0, f});
    chk({31'h0, drv}, {31'h0, ~f});
  endtask

  task automatic clear_droop();
    @(posedge sys_clk);
    clr_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    clr_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the sequence needs about 24000 cycles.
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    outs(2, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++) rd(RA[i], RV[i]);
    for (int i = 0; i < 5; i++) begin
      wr(CA[i], CW[i]);
      rd(CA[i], CM[i]);
    end
    for (int i = 0; i < 5; i++) wr(CA[i], CR[i]);
    // Four forward encoder edges make a droop of minus four.
    src.enc_steps(4, 1'b1);
    outs(8, 1'b1, 1'b0);
    rd(8'h30, 32'hfffffffc);
    chk(spd, -32'sd100);
    wr(8'h18, 32'h4);
    outs(2, 1'b0, 1'b0);
    wr(8'h18, 32'h5);
    outs(2, 1'b1, 1'b0);
    wr(8'h24, 32'h88);
    outs(2, 1'b0, 1'b0);
    wr(8'h24, 32'h24);
    outs(2, 1'b1, 1'b0);
    // A write while the clock enable is low must be lost.
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(8'h18, 32'h7);
    ce <= 1'b1;
    rd(8'h18, 32'h5);
    // Two commands at a ratio of two cancel the four feedback pulses.
    wr(8'h00, 32'h2);
    src.cmd_pulses(2, 1'b1);
    repeat (40) @(posedge sys_clk);
    rd(8'h30, 32'h0);
    // Smoothing of 100 cycles spaces the two scaled pulses of one command.
    wr(8'h10, 32'd100);
    src.cmd_pulses(1, 1'b1);
    repeat (50) @(posedge sys_clk);
    rd(8'h30, 32'h1);
    repeat (100) @(posedge sys_clk);
    rd(8'h30, 32'h2);
    wr(8'h10, 32'h0);
    src.enc_steps(2, 1'b1);
    wr(8'h20, 32'h0);
    src.enc_steps(3, 1'b1);
    repeat (8) @(posedge sys_clk);
    rd(8'h30, 32'hfffffffd);
    wr(8'h1c, 32'h2);
    outs(4, 1'b1, 1'b1);
    rd(8'h2c, 32'h3);
    clear_droop();
    rd(8'h30, 32'h0);
    wr(8'h1c, 32'd9999);
    wr(8'h28, 32'h1);
    outs(2, 1'b1, 1'b0);
    // Six hundred commands at ratio twenty give a droop far past 9999.
    wr(8'h00, 32'd20);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'd100);
    src.cmd_pulses(600, 1'b1);
    // Zero loop gain leaves the feed-forward alone: the backlog drains one
    // pulse a cycle, so a 20-cycle window holds 20 pulses, at 100 percent.
    repeat (100) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(spd, 32'd2000);
    repeat (20000) @(posedge sys_clk);
    rd(8'h30, 32'd12000);
    outs(1, 1'b0, 1'b0);
    wr(8'h1c, 32'd10000);
    outs(4, 1'b0, 1'b1);
    // Level clear mode holds the counter at zero while the pin stays high.
    wr(8'h20, 32'h1);
    clr_in <= 1'b1;
    src.enc_steps(2, 1'b1);
    repeat (4) @(posedge sys_clk);
    rd(8'h30, 32'h0);
    final_report();
  end
endmodule
